//--- core/dmc_map.svh
// offsets, field positions, reset values and timing counts of the csr bank
// Summary of operation
// - state and link tuning: read-only, eeprom-loaded
// - link tuning bit4 ack, bit5 detect; reset 04h
// - debug bits 4:0 pick group; 0 link training
// - debug bits 7:5 pick monitored port
// - debug bit 8 set starts capture
// - debug data returns captured 32-bit word
// - debug registers exist on upstream port only
// - strap low enables reference clock buffer
// - enabled buffer drives its output pairs
// - strap high: buffer off, own input used
// - opmode bits 19:16 disable output pairs
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH

`define DMC_OFF_LED1      12'h32c
`define DMC_OFF_LTSSM     12'h33c
`define DMC_OFF_MAC       12'h340
`define DMC_OFF_TL        12'h344
`define DMC_OFF_DBG_CTRL  12'h348
`define DMC_OFF_DBG_DATA  12'h34c
`define DMC_OFF_OPMODE    12'h098

`define DMC_RST_LED1      32'h0000_0000
`define DMC_RST_LTSSM     8'h00
`define DMC_RST_MAC       16'h0004
`define DMC_RST_TL        8'h03
`define DMC_RST_DBG_CTRL  9'h000
`define DMC_RST_DBG_DATA  32'h0000_0000
`define DMC_RST_CLKBUF    8'h00

`define DMC_MAC_ACK_BIT   4
`define DMC_MAC_DET_BIT   5
`define DMC_DBG_MODE_MSB  4
`define DMC_DBG_PORT_LSB  5
`define DMC_DBG_PORT_MSB  7
`define DMC_DBG_START_BIT 8
`define DMC_CLKBUF_LSB    16
`define DMC_CLKBUF_MSB    23

`define DMC_STRAP_WAIT    3'h5

`endif

//--- core/dmc_pkg.sv
// types shared by the csr bank and its users
package dmc_pkg;
  typedef enum logic [1:0] {
    DMC_EEP_LTSSM,
    DMC_EEP_MAC,
    DMC_EEP_OPMODE
  } dmc_eep_tgt_e;

  typedef enum logic {
    DMC_STRAP_WAIT,
    DMC_STRAP_DONE
  } dmc_strap_e;

  typedef logic [4:0] dmc_mode_t;
  localparam dmc_mode_t DMC_GRP_LTSSM = 5'h00;
endpackage

//--- core/dmc_csr_bank.sv
// debug, tuning and reference clock buffer csr bank
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"

module dmc_csr_bank (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  input  wire logic [11:0]           i_reg_addr,
  input  wire logic [31:0]           i_reg_wdata,
  output logic      [31:0]           o_reg_rdata,
  output logic                       o_reg_rvalid,
  input  wire logic                  i_eep_wr,
  input  wire dmc_pkg::dmc_eep_tgt_e i_eep_tgt,
  input  wire logic [31:0]           i_eep_data,
  input  wire logic                  i_upstream,
  input  wire logic                  i_clock_buffer_powerdown_strap,
  input  wire logic [31:0]           i_dbg_probe,
  output dmc_pkg::dmc_mode_t         o_dbg_mode,
  output logic      [2:0]            o_dbg_port,
  output logic                       o_dbg_capturing,
  output logic      [7:0]            o_led_setting_byte0,
  output logic      [7:0]            o_led_setting_byte1,
  output logic      [7:0]            o_led_setting_byte2,
  output logic      [7:0]            o_led_setting_byte3,
  output logic      [7:0]            o_link_state_machine_tuning,
  output logic      [15:0]           o_link_layer_tuning,
  output logic                       o_adaptive_ack,
  output logic                       o_fixed_detect_suppress,
  output logic      [7:0]            o_transaction_layer_tuning,
  output logic                       o_clkbuf_en,
  output logic                       o_ref_from_switch_in,
  output logic      [3:0]            o_buffered_ref_clock_out_en
);

  logic [31:0] led_r;
  logic [31:0] led_nxt;
  logic [7:0]  ltssm_r;
  logic [7:0]  ltssm_nxt;
  logic [15:0] mac_r;
  logic [15:0] mac_nxt;
  logic [7:0]  tl_r;
  logic [7:0]  tl_nxt;
  logic [8:0]  dbg_ctrl_r;
  logic [8:0]  dbg_ctrl_nxt;
  logic [31:0] cap_r;
  logic [31:0] cap_nxt;
  logic [7:0]  clkbuf_r;
  logic [7:0]  clkbuf_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;

  logic [2:0]  sync_r;
  logic [2:0]  sync_nxt;
  logic        filt_r;
  logic        filt_nxt;
  logic        lat_r;
  logic        lat_nxt;
  logic [2:0]  cnt_r;
  logic [2:0]  cnt_nxt;
  dmc_pkg::dmc_strap_e st_r;
  dmc_pkg::dmc_strap_e st_nxt;

  logic wr_led;
  logic wr_tl;
  logic wr_dbg;
  logic wr_op;

  assign wr_led = i_reg_wr && (i_reg_addr == `DMC_OFF_LED1);
  assign wr_tl  = i_reg_wr && (i_reg_addr == `DMC_OFF_TL);
  assign wr_dbg = i_reg_wr && i_upstream &&
                  (i_reg_addr == `DMC_OFF_DBG_CTRL);
  assign wr_op  = i_reg_wr && (i_reg_addr == `DMC_OFF_OPMODE);

  // register group
  always_comb begin
    led_nxt      = led_r;
    ltssm_nxt    = ltssm_r;
    mac_nxt      = mac_r;
    tl_nxt       = tl_r;
    dbg_ctrl_nxt = dbg_ctrl_r;
    cap_nxt      = cap_r;
    clkbuf_nxt   = clkbuf_r;
    if (wr_led) begin
      led_nxt = i_reg_wdata;
    end
    if (wr_tl) begin
      tl_nxt = i_reg_wdata[7:0];
    end
    if (wr_dbg) begin
      dbg_ctrl_nxt = i_reg_wdata[`DMC_DBG_START_BIT:0];
    end
    if (wr_op) begin
      clkbuf_nxt = i_reg_wdata[`DMC_CLKBUF_MSB:`DMC_CLKBUF_LSB];
    end
    // only the eeprom loader alters ltssm and mac; opmode also takes register writes
    if (i_eep_wr) begin
      unique case (i_eep_tgt)
        dmc_pkg::DMC_EEP_LTSSM:  ltssm_nxt = i_eep_data[7:0];
        dmc_pkg::DMC_EEP_MAC:    mac_nxt   = i_eep_data[15:0];
        dmc_pkg::DMC_EEP_OPMODE: begin
          clkbuf_nxt = i_eep_data[`DMC_CLKBUF_MSB:`DMC_CLKBUF_LSB];
        end
        default: ;
      endcase
    end
    if (i_upstream && dbg_ctrl_r[`DMC_DBG_START_BIT]) begin
      cap_nxt = i_dbg_probe;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      led_r      <= `DMC_RST_LED1;
      ltssm_r    <= `DMC_RST_LTSSM;
      mac_r      <= `DMC_RST_MAC;
      tl_r       <= `DMC_RST_TL;
      dbg_ctrl_r <= `DMC_RST_DBG_CTRL;
      cap_r      <= `DMC_RST_DBG_DATA;
      clkbuf_r   <= `DMC_RST_CLKBUF;
    end else begin
      led_r      <= led_nxt;
      ltssm_r    <= ltssm_nxt;
      mac_r      <= mac_nxt;
      tl_r       <= tl_nxt;
      dbg_ctrl_r <= dbg_ctrl_nxt;
      cap_r      <= cap_nxt;
      clkbuf_r   <= clkbuf_nxt;
    end
  end

  // read group
  always_comb begin
    rdata_nxt  = 32'h0000_0000;
    rvalid_nxt = i_reg_rd;
    if (i_reg_rd) begin
      // reserved bits and unmapped offsets read zero
      unique case (i_reg_addr)
        `DMC_OFF_LED1:   rdata_nxt = led_r;
        `DMC_OFF_LTSSM:  rdata_nxt = {24'h00_0000, ltssm_r};
        `DMC_OFF_MAC:    rdata_nxt = {16'h0000, mac_r};
        `DMC_OFF_TL:     rdata_nxt = {24'h00_0000, tl_r};
        `DMC_OFF_OPMODE: rdata_nxt = {8'h00, clkbuf_r, 16'h0000};
        `DMC_OFF_DBG_CTRL: begin
          if (i_upstream) begin
            rdata_nxt = {23'h00_0000, dbg_ctrl_r};
          end
        end
        `DMC_OFF_DBG_DATA: begin
          if (i_upstream) begin
            rdata_nxt = cap_r;
          end
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // strap group: sync, filter, then latch once after reset
  always_comb begin
    sync_nxt = {sync_r[1:0], i_clock_buffer_powerdown_strap};
    // second and third stage must agree before the level counts
    filt_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : filt_r;
    cnt_nxt  = cnt_r;
    lat_nxt  = lat_r;
    st_nxt   = st_r;
    unique case (st_r)
      dmc_pkg::DMC_STRAP_WAIT: begin
        // wait lets the synchroniser flush its reset zeros
        if (cnt_r == `DMC_STRAP_WAIT) begin
          lat_nxt = filt_r;
          st_nxt  = dmc_pkg::DMC_STRAP_DONE;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      dmc_pkg::DMC_STRAP_DONE: ;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync_r <= 3'h0;
      filt_r <= 1'b0;
      cnt_r  <= 3'h0;
      lat_r  <= 1'b1;
      st_r   <= dmc_pkg::DMC_STRAP_WAIT;
    end else begin
      sync_r <= sync_nxt;
      filt_r <= filt_nxt;
      cnt_r  <= cnt_nxt;
      lat_r  <= lat_nxt;
      st_r   <= st_nxt;
    end
  end

  assign o_reg_rdata                 = rdata_r;
  assign o_reg_rvalid                = rvalid_r;
  assign o_dbg_mode                  = dbg_ctrl_r[`DMC_DBG_MODE_MSB:0];
  assign o_dbg_port  = dbg_ctrl_r[`DMC_DBG_PORT_MSB:`DMC_DBG_PORT_LSB];
  assign o_dbg_capturing = i_upstream && dbg_ctrl_r[`DMC_DBG_START_BIT];
  assign o_led_setting_byte0         = led_r[7:0];
  assign o_led_setting_byte1         = led_r[15:8];
  assign o_led_setting_byte2         = led_r[23:16];
  assign o_led_setting_byte3         = led_r[31:24];
  assign o_link_state_machine_tuning = ltssm_r;
  assign o_link_layer_tuning         = mac_r;
  assign o_adaptive_ack          = mac_r[`DMC_MAC_ACK_BIT];
  assign o_fixed_detect_suppress = mac_r[`DMC_MAC_DET_BIT];
  assign o_transaction_layer_tuning  = tl_r;
  // latched strap picks the reference source
  assign o_clkbuf_en = (st_r == dmc_pkg::DMC_STRAP_DONE) && !lat_r;
  assign o_ref_from_switch_in = !o_clkbuf_en;
  // enabled buffer feeds pairs not disabled
  assign o_buffered_ref_clock_out_en = {4{o_clkbuf_en}} & ~clkbuf_r[3:0];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_strap_low;
    $past(i_sys_rst) ##1 (!i_clock_buffer_powerdown_strap) [*8];
  endsequence
  sequence s_strap_high;
    $past(i_sys_rst) ##1 i_clock_buffer_powerdown_strap [*8];
  endsequence

  a_ltssm_ro_hold: assert property (
    (i_reg_wr && !i_eep_wr) |=> $stable(ltssm_r) && $stable(mac_r))
    else $error("tuning changed without eeprom load");
  a_mac_reset_val: assert property (
    $past(i_sys_rst) |-> (o_link_layer_tuning == 16'h0004) &&
      o_adaptive_ack == o_link_layer_tuning[4])
    else $error("link tuning reset value wrong");
  a_dbg_mode_wr: assert property (
    wr_dbg |=> o_dbg_mode == $past(i_reg_wdata[4:0]))
    else $error("debug mode not written");
  a_dbg_port_wr: assert property (
    wr_dbg |=> o_dbg_port == $past(i_reg_wdata[7:5]))
    else $error("debug port not written");
  a_capture_flow: assert property (
    (wr_dbg && i_reg_wdata[8]) ##1 i_upstream
      |=> cap_r == $past(i_dbg_probe))
    else $error("capture did not follow start");
  a_capture_idle: assert property (
    !o_dbg_capturing |=> $stable(cap_r))
    else $error("capture moved while not started");
  a_capture_read: assert property (
    (i_reg_rd && i_upstream && i_reg_addr == 12'h34c)
      |=> o_reg_rvalid && o_reg_rdata == $past(cap_r))
    else $error("captured word not returned");
  a_read_answer: assert property (
    i_reg_rd |=> o_reg_rvalid)
    else $error("read strobe got no answer");
  a_down_hidden: assert property (
    (i_reg_rd && !i_upstream && i_reg_addr == 12'h348)
      |=> o_reg_rdata == 32'h0000_0000)
    else $error("debug register visible downstream");
  a_strap_low_en: assert property (
    s_strap_low |-> o_clkbuf_en)
    else $error("buffer not enabled on low strap");
  a_buffer_drive: assert property (
    (o_clkbuf_en && clkbuf_r == 8'h00)
      |-> o_buffered_ref_clock_out_en == 4'hf)
    else $error("enabled buffer not driving pairs");
  a_strap_high_off: assert property (
    s_strap_high |-> !o_clkbuf_en && o_ref_from_switch_in)
    else $error("buffer enabled on high strap");
  a_strap_once: assert property (
    (st_r == dmc_pkg::DMC_STRAP_DONE) |=> $stable(o_clkbuf_en))
    else $error("buffer state moved after strap latch");
  a_pair_disable: assert property (
    (wr_op && !i_eep_wr && i_reg_wdata[16])
      |=> !o_buffered_ref_clock_out_en[0])
    else $error("pair disable ignored");
  a_rsvd_zero: assert property (
    (i_reg_rd && i_reg_addr == 12'h33c) |=> o_reg_rdata[31:8] == 24'h0)
    else $error("reserved bits not zero");

endmodule
`default_nettype wire

//--- testbench/dmc_csr_bank_tb.sv
// self-checking bench for the debug, tuning and clock buffer csr bank
`timescale 1ns/1ps
`default_nettype none
`include "dmc_map.svh"

module dmc_csr_bank_tb;
  logic                  clk;
  logic                  rst;
  logic                  wr;
  logic                  rd;
  logic [11:0]           addr;
  logic [31:0]           wdata;
  logic [31:0]           rdata;
  logic                  rvalid;
  logic                  eep_wr;
  dmc_pkg::dmc_eep_tgt_e eep_tgt;
  logic [31:0]           eep_data;
  logic                  upstream;
  logic                  strap;
  logic [31:0]           probe;
  dmc_pkg::dmc_mode_t    mode;
  logic [2:0]            port;
  logic                  capt;
  logic [7:0]            led [4];
  logic [7:0]            lsm;
  logic [15:0]           llt;
  logic                  ack;
  logic                  det;
  logic [7:0]            tlt;
  logic                  cben;
  logic                  refsw;
  logic [3:0]            outen;
  int                    num_errors;
  int                    checked;
  logic [11:0]           adr_tab [8];
  logic [31:0]           rst_tab [8];

  dmc_csr_bank DUT (
    .i_clk                          (clk),
    .i_sys_rst                      (rst),
    .i_reg_wr                       (wr),
    .i_reg_rd                       (rd),
    .i_reg_addr                     (addr),
    .i_reg_wdata                    (wdata),
    .o_reg_rdata                    (rdata),
    .o_reg_rvalid                   (rvalid),
    .i_eep_wr                       (eep_wr),
    .i_eep_tgt                      (eep_tgt),
    .i_eep_data                     (eep_data),
    .i_upstream                     (upstream),
    .i_clock_buffer_powerdown_strap (strap),
    .i_dbg_probe                    (probe),
    .o_dbg_mode                     (mode),
    .o_dbg_port                     (port),
    .o_dbg_capturing                (capt),
    .o_led_setting_byte0            (led[0]),
    .o_led_setting_byte1            (led[1]),
    .o_led_setting_byte2            (led[2]),
    .o_led_setting_byte3            (led[3]),
    .o_link_state_machine_tuning    (lsm),
    .o_link_layer_tuning            (llt),
    .o_adaptive_ack                 (ack),
    .o_fixed_detect_suppress        (det),
    .o_transaction_layer_tuning     (tlt),
    .o_clkbuf_en                    (cben),
    .o_ref_from_switch_in           (refsw),
    .o_buffered_ref_clock_out_en    (outen)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read strobe is one cycle; answer looked at in its single valid cycle
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    int n;
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (rvalid !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, rvalid, 1'b1);
      give_verdict();
    end else begin
      chk(rdata, exp);
    end
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic eep(input dmc_pkg::dmc_eep_tgt_e t, input logic [31:0] d);
    @(negedge clk);
    eep_wr = 1'b1;
    eep_tgt = t;
    eep_data = d;
    @(negedge clk);
    eep_wr = 1'b0;
  endtask

  // strap is taken a few edges after release, so settle before checking
  task automatic do_reset(input logic s);
    strap = s;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (9) @(negedge clk);
  endtask

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h000;
    wdata = 32'h0;
    eep_wr = 1'b0;
    eep_tgt = dmc_pkg::DMC_EEP_LTSSM;
    eep_data = 32'h0;
    upstream = 1'b1;
    strap = 1'b0;
    probe = 32'h0;
    num_errors = 0;
    checked = 0;
    adr_tab = '{`DMC_OFF_LED1, `DMC_OFF_LTSSM, `DMC_OFF_MAC, `DMC_OFF_TL,
                `DMC_OFF_DBG_CTRL, `DMC_OFF_DBG_DATA, `DMC_OFF_OPMODE,
                12'h330};
    rst_tab = '{32'h0, 32'h0, 32'h4, 32'h3, 32'h0, 32'h0, 32'h0, 32'h0};
    do_reset(1'b0);
    for (int i = 0; i < 8; i++) rd_chk(adr_tab[i], rst_tab[i]);
    chk(32'({cben, refsw, outen}), 32'h2f);
    reg_wr(`DMC_OFF_LED1, 32'ha5c3_1e7f);
    rd_chk(`DMC_OFF_LED1, 32'ha5c3_1e7f);
    chk({led[3], led[2], led[1], led[0]}, 32'ha5c3_1e7f);
    reg_wr(`DMC_OFF_TL, 32'hffff_ffff);
    rd_chk(`DMC_OFF_TL, 32'h0000_00ff);
    chk(32'(tlt), 32'hff);
    reg_wr(`DMC_OFF_LTSSM, 32'hffff_ffff);
    reg_wr(`DMC_OFF_MAC, 32'hffff_ffff);
    rd_chk(`DMC_OFF_LTSSM, 32'h0);
    rd_chk(`DMC_OFF_MAC, 32'h4);
    eep(dmc_pkg::DMC_EEP_LTSSM, 32'h0000_01ab);
    rd_chk(`DMC_OFF_LTSSM, 32'h0000_00ab);
    chk(32'(lsm), 32'h0000_00ab);
    eep(dmc_pkg::DMC_EEP_MAC, 32'h0000_0030);
    chk(32'({llt, ack, det}), 32'h0000_00c3);
    eep(dmc_pkg::DMC_EEP_MAC, 32'h0000_0010);
    eep(dmc_pkg::dmc_eep_tgt_e'(2'h3), 32'hffff_ffff);
    rd_chk(`DMC_OFF_MAC, 32'h10);
    chk(32'({ack, det}), 32'h2);
    probe = 32'h1234_5678;
    reg_wr(`DMC_OFF_DBG_CTRL, 32'hffff_ff21);
    rd_chk(`DMC_OFF_DBG_CTRL, 32'h0000_0121);
    chk(32'({mode, port, capt}), 32'h0000_0013);
    rd_chk(`DMC_OFF_DBG_DATA, 32'h1234_5678);
    probe = 32'hcafe_0001;
    rd_chk(`DMC_OFF_DBG_DATA, 32'hcafe_0001);
    reg_wr(`DMC_OFF_DBG_CTRL, 32'h0000_00e0);
    chk(32'({mode, port, capt}), 32'h0000_000e);
    reg_wr(`DMC_OFF_DBG_CTRL, 32'h0000_0121);
    upstream = 1'b0;
    reg_wr(`DMC_OFF_DBG_CTRL, 32'h0000_00e0);
    chk(32'(capt), 32'h0);
    rd_chk(`DMC_OFF_DBG_CTRL, 32'h0);
    rd_chk(`DMC_OFF_DBG_DATA, 32'h0);
    upstream = 1'b1;
    rd_chk(`DMC_OFF_DBG_CTRL, 32'h0000_0121);
    reg_wr(`DMC_OFF_OPMODE, 32'hffa5_ffff);
    rd_chk(`DMC_OFF_OPMODE, 32'h00a5_0000);
    chk(32'(outen), 32'ha);
    eep(dmc_pkg::DMC_EEP_OPMODE, 32'h0030_0000);
    rd_chk(`DMC_OFF_OPMODE, 32'h0030_0000);
    chk(32'(outen), 32'hf);
    do_reset(1'b1);
    chk(32'({cben, refsw, outen}), 32'h10);
    rd_chk(`DMC_OFF_MAC, 32'h4);
    // the strap is only taken once per reset
    strap = 1'b0;
    repeat (10) @(negedge clk);
    chk(32'({cben, refsw, outen}), 32'h10);
    give_verdict();
  end
endmodule
`default_nettype wire
